// ### design/eeprom_access_cmd.sv
/*
  Serial-EEPROM access command interpreter behind the slave SMBus port.
  It parses the command bytes, launches one-byte EEPROM reads and writes on
  the master SMBus engine, and returns data and error flags to the host.
  Assumes a master SMBus engine on i_clk that reports its events as pulses,
  and that the slave SMBus pins arrive asynchronously.
*/
// Functional notes
// - first byte after slave address is the command code identifying EEPROM access.
// - byte count present only in block transfers; byte and word forms skip it.
// - returned byte count gives the following bytes, status byte included.
// - position two is the command byte: operation, override and error flags.
// - position three is the EEPROM bus address, used only under override.
// - positions four and five are low and high EEPROM byte address.
// - position six is data: written by host, returned by device on read.
// - command bit zero: zero writes the EEPROM, one reads it.
// - command bit one selects supplied address, else configured EEPROM address.
// - command bit three flags unexpected master-bus nack; reading clears it.
// - command bit four flags sixteen consecutive lost arbitrations; read clears.
// - command bit five flags misplaced start or stop; reading clears it.
// - the three flags behave like the master bus status flags.
`timescale 1ns/1ps
`include "eeprom_cmd_params.svh"
module eeprom_access_cmd #(
  parameter int ARB_LOSS_LIMIT = `ARB_LOSS_LIMIT
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // slave smbus pins, data is open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // configuration
  input wire logic [6:0] i_slave_addr,
  input wire logic [6:0] i_configured_eeprom_address,
  // request to the master smbus engine
  output logic o_ee_req,
  output logic o_ee_read,
  output logic [6:0] o_ee_dev_addr,
  output logic [15:0] o_ee_byte_addr,
  output logic [7:0] o_ee_wdata,
  // completion and events from the master smbus engine
  input wire logic i_ee_done,
  input wire logic [7:0] i_ee_rdata,
  input wire logic i_ee_nack,
  input wire logic i_ee_arb_lost,
  input wire logic i_ee_arb_won,
  input wire logic i_ee_bus_cond_err,
  // status
  output logic o_busy,
  output logic o_nack_error_flag,
  output logic o_arbitration_lost_flag,
  output logic o_bus_condition_error_flag
);
  localparam int ARB_W = $clog2(ARB_LOSS_LIMIT + 1);

  slave_byte_if bus ();

  // ==========================================================================
  // pin synchronisers
  logic scl_meta, scl_sync, sda_meta, sda_sync;

  // two flops on each pin; the first flop is read only by the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      scl_meta <= i_scl;
      scl_sync <= scl_meta;
      sda_meta <= i_sda;
      sda_sync <= sda_meta;
    end
  end

  assign bus.scl = scl_sync;
  assign bus.sda = sda_sync;
  assign o_sda_out = 1'b0; // open drain: only ever pulls low

  // ==========================================================================
  // byte engine
  smbus_slave_engine engine (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_slave_addr(i_slave_addr),
    .bus(bus.engine),
    .o_sda_oe(o_sda_oe)
  );

  // ==========================================================================
  // parsed command state
  eeprom_cmd_pkg::byte_pos_t rx_pos, tx_pos;
  logic [7:0] slave_command_code, block_byte_count;
  logic read_write_select, address_override, in_write;
  logic [7:0] eeprom_bus_address, eeprom_byte_addr_low, eeprom_byte_addr_high;
  logic [7:0] wdata, rdata;
  logic [2:0] err_flags;
  logic [ARB_W-1:0] arb_cnt;

  // command code decode
  wire code_is_ee = (slave_command_code[`CODE_FUNC_MSB:0] == `CODE_EE_FUNC);
  wire block_mode = slave_command_code[`CODE_BLOCK_BIT];
  wire new_block = bus.rx_data[`CODE_BLOCK_BIT];

  // position that follows the command code: the count only in block form
  wire eeprom_cmd_pkg::byte_pos_t after_code = new_block ? `POS_COUNT : `POS_CMD;
  wire eeprom_cmd_pkg::byte_pos_t read_start = block_mode ? `POS_COUNT : `POS_CMD;

  // next receive and transmit positions, saturating so surplus bytes fall away harmlessly
  wire eeprom_cmd_pkg::byte_pos_t rx_pos_inc = (rx_pos == `POS_LIMIT) ? rx_pos : rx_pos + 3'h1;
  wire eeprom_cmd_pkg::byte_pos_t tx_pos_inc = (tx_pos == `POS_LIMIT) ? tx_pos : tx_pos + 3'h1;

  // per-position write strobes for an accepted byte
  wire rx_code = bus.rx_valid && in_write && (rx_pos == `POS_CODE);
  wire rx_count = bus.rx_valid && in_write && (rx_pos == `POS_COUNT);
  wire rx_cmd = bus.rx_valid && in_write && (rx_pos == `POS_CMD);
  wire rx_busadr = bus.rx_valid && in_write && (rx_pos == `POS_BUSADR);
  wire rx_low = bus.rx_valid && in_write && (rx_pos == `POS_LOW);
  wire rx_high = bus.rx_valid && in_write && (rx_pos == `POS_HIGH);
  wire rx_data = bus.rx_valid && in_write && (rx_pos == `POS_DATA);

  // ==========================================================================
  // launch decision at stop
  // a read needs bytes through the upper address, a write also needs data
  wire enough_read = (rx_pos > `POS_HIGH);
  wire enough_write = (rx_pos > `POS_DATA);
  wire enough = read_write_select ? enough_read : enough_write;
  wire launch = bus.stop && in_write && code_is_ee && enough && !o_busy;

  // override takes the left-justified address; bit zero is dropped
  wire [6:0] target_addr = address_override ? eeprom_bus_address[7:1]
                                            : i_configured_eeprom_address;

  // ==========================================================================
  // read-back byte selection
  // reserved bits seven, six and two read back as zero
  wire [7:0] cmd_byte = {2'b00, err_flags, 1'b0, address_override, read_write_select};
  logic [7:0] tx_sel;

  // mux the byte at the current transmit position
  always_comb begin
    unique case (tx_pos)
      `POS_COUNT: tx_sel = `RD_BYTE_COUNT;
      `POS_CMD: tx_sel = cmd_byte;
      `POS_BUSADR: tx_sel = eeprom_bus_address;
      `POS_LOW: tx_sel = eeprom_byte_addr_low;
      `POS_HIGH: tx_sel = eeprom_byte_addr_high;
      `POS_DATA: tx_sel = rdata;
      default: tx_sel = 8'h00;
    endcase
  end

  assign bus.tx_data = tx_sel;

  // the command byte being taken by the engine is what clears the flags
  wire flags_read = bus.tx_take && (tx_pos == `POS_CMD);

  // ==========================================================================
  // positions and transaction direction
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_pos <= `POS_CODE;
      tx_pos <= `POS_CODE;
      in_write <= 1'b0;
    end else begin
      if (bus.addr_valid) begin
        in_write <= ~bus.addr_read;
        rx_pos <= `POS_CODE;
        tx_pos <= read_start;
      end else if (bus.start) begin
        in_write <= 1'b0;
      end else begin
        if (rx_code) rx_pos <= after_code;
        else if (bus.rx_valid && in_write) rx_pos <= rx_pos_inc;
        if (bus.tx_take) tx_pos <= tx_pos_inc;
      end
    end
  end

  // ==========================================================================
  // command field capture; error bits written by the host are ignored
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slave_command_code <= 8'h00;
      block_byte_count <= 8'h00;
      read_write_select <= 1'b0;
      address_override <= 1'b0;
      eeprom_bus_address <= 8'h00;
      eeprom_byte_addr_low <= 8'h00;
      eeprom_byte_addr_high <= 8'h00;
      wdata <= 8'h00;
    end else begin
      if (rx_code) slave_command_code <= bus.rx_data;
      if (rx_count) block_byte_count <= bus.rx_data;
      if (rx_cmd) begin
        read_write_select <= bus.rx_data[`CMD_OP_BIT];
        address_override <= bus.rx_data[`CMD_OVR_BIT];
      end
      if (rx_busadr) eeprom_bus_address <= bus.rx_data;
      if (rx_low) eeprom_byte_addr_low <= bus.rx_data;
      if (rx_high) eeprom_byte_addr_high <= bus.rx_data;
      if (rx_data) wdata <= bus.rx_data;
    end
  end

  // ==========================================================================
  // master request and completion
  // the request fields are held stable while busy, so the engine may sample them late; o_ee_req itself pulses for one cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ee_req <= 1'b0;
      o_ee_read <= 1'b0;
      o_ee_dev_addr <= 7'h00;
      o_ee_byte_addr <= 16'h0000;
      o_ee_wdata <= 8'h00;
      o_busy <= 1'b0;
      rdata <= 8'h00;
    end else begin
      o_ee_req <= launch;
      if (launch) begin
        o_ee_read <= read_write_select;
        o_ee_dev_addr <= target_addr;
        o_ee_byte_addr <= {eeprom_byte_addr_high, eeprom_byte_addr_low};
        o_ee_wdata <= wdata;
        o_busy <= 1'b1;
      end else if (i_ee_done) begin
        o_busy <= 1'b0;
      end
      if (i_ee_done && o_busy && o_ee_read) rdata <= i_ee_rdata;
    end
  end

  // ==========================================================================
  // consecutive arbitration losses
  // a won arbitration or a fresh request restarts the run
  wire arb_limit_hit = i_ee_arb_lost && (arb_cnt == ARB_W'(ARB_LOSS_LIMIT - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arb_cnt <= '0;
    end else if (launch || i_ee_arb_won) begin
      arb_cnt <= '0;
    end else if (i_ee_arb_lost && arb_cnt != ARB_W'(ARB_LOSS_LIMIT)) begin
      arb_cnt <= arb_cnt + ARB_W'(1);
    end
  end

  // ==========================================================================
  // read-clear error flags, bit order nack, arbitration, bus condition
  // an event in the clearing cycle survives, matching the master status flags
  wire [2:0] err_set = {i_ee_bus_cond_err, arb_limit_hit, i_ee_nack};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_err
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          err_flags[g] <= 1'(`ERR_FLAGS_RESET >> g);
        end else begin
          err_flags[g] <= err_set[g] | (err_flags[g] & ~flags_read);
        end
      end
    end
  endgenerate

  assign o_nack_error_flag = err_flags[0];
  assign o_arbitration_lost_flag = err_flags[1];
  assign o_bus_condition_error_flag = err_flags[2];
endmodule

// ### design/eeprom_cmd_params.svh
/*
  Constants of the serial-EEPROM access command: byte positions of the
  slave transfer, command-byte field positions, code-field layout and counts.
  Assumes inclusion by bare name from any file that needs one of them.
*/
`ifndef EEPROM_CMD_PARAMS_SVH
`define EEPROM_CMD_PARAMS_SVH

// ==========================================================================
// byte positions after the slave address
`define POS_CODE 3'h0
`define POS_COUNT 3'h1
`define POS_CMD 3'h2
`define POS_BUSADR 3'h3
`define POS_LOW 3'h4
`define POS_HIGH 3'h5
`define POS_DATA 3'h6
`define POS_LIMIT 3'h7

// ==========================================================================
// command byte fields
`define CMD_OP_BIT 0
`define CMD_OVR_BIT 1
`define CMD_NACK_BIT 3
`define CMD_ARB_BIT 4
`define CMD_COND_BIT 5

// ==========================================================================
// slave command code layout: function in the low bits, block flag on top
`define CODE_FUNC_MSB 2
`define CODE_EE_FUNC 3'h1
`define CODE_BLOCK_BIT 7

// ==========================================================================
// counts and reset values
`define RD_BYTE_COUNT 8'h05
`define ARB_LOSS_LIMIT 16
`define ERR_FLAGS_RESET 3'h0

`endif

// ### design/eeprom_cmd_pkg.sv
/*
  Types shared by the EEPROM access command block and its byte engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package eeprom_cmd_pkg;
  // byte engine states
  typedef enum logic [2:0] {ENG_IDLE, ENG_RX, ENG_ACK, ENG_TX, ENG_TXACK} engine_state_t;
  // position of a byte within the slave transfer
  typedef logic [2:0] byte_pos_t;
endpackage

// ### design/slave_byte_if.sv
/*
  Byte-level carrier between the command parser and the slave byte engine.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface slave_byte_if;
  logic scl;
  logic sda;
  logic start;
  logic stop;
  logic addr_valid;
  logic addr_read;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_take;
  logic [7:0] tx_data;
  modport engine(input scl, sda, tx_data,
                 output start, stop, addr_valid, addr_read, rx_valid, rx_data, tx_take);
  modport parser(output scl, sda, tx_data,
                 input start, stop, addr_valid, addr_read, rx_valid, rx_data, tx_take);
endinterface

// ### design/smbus_slave_engine.sv
/*
  Slave SMBus byte engine: conditions, address match, byte receive with ack,
  byte transmit with host ack.
  Assumes scl and sda in the interface are already synchronised to i_clk.
*/
`timescale 1ns/1ps
module smbus_slave_engine (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // configuration
  input wire logic [6:0] i_slave_addr,
  // byte side
  slave_byte_if.engine bus,
  // open-drain data enable
  output logic o_sda_oe
);
  eeprom_cmd_pkg::engine_state_t state;
  logic scl_d, sda_d, first, reading, got_byte, addr_valid, rx_valid, tx_take;
  logic [2:0] bit_cnt;
  logic [7:0] shreg, rx_data;
  logic scl_rise, scl_fall, start_cond, stop_cond, addr_hit;
  logic [7:0] next_shreg;

  // ==========================================================================
  // edge and condition decode
  assign scl_rise = bus.scl & ~scl_d;
  assign scl_fall = ~bus.scl & scl_d;
  assign start_cond = bus.scl & scl_d & sda_d & ~bus.sda;
  assign stop_cond = bus.scl & scl_d & ~sda_d & bus.sda;
  assign next_shreg = {shreg[6:0], bus.sda};
  assign addr_hit = (next_shreg[7:1] == i_slave_addr);
  assign bus.start = start_cond;
  assign bus.stop = stop_cond;
  assign bus.addr_valid = addr_valid;
  assign bus.addr_read = reading;
  assign bus.rx_valid = rx_valid;
  assign bus.rx_data = rx_data;
  assign bus.tx_take = tx_take;

  // ==========================================================================
  // bit sequencing; a start anywhere restarts, so a lost frame self-heals
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= eeprom_cmd_pkg::ENG_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      first <= 1'b0;
      reading <= 1'b0;
      got_byte <= 1'b0;
      addr_valid <= 1'b0;
      rx_valid <= 1'b0;
      tx_take <= 1'b0;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      rx_data <= 8'h00;
      o_sda_oe <= 1'b0;
    end else begin
      scl_d <= bus.scl;
      sda_d <= bus.sda;
      addr_valid <= 1'b0;
      rx_valid <= 1'b0;
      tx_take <= 1'b0;
      if (start_cond) begin
        state <= eeprom_cmd_pkg::ENG_RX;
        bit_cnt <= 3'h0;
        first <= 1'b1;
        got_byte <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state <= eeprom_cmd_pkg::ENG_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        unique case (state)
          eeprom_cmd_pkg::ENG_IDLE: begin
          end
          eeprom_cmd_pkg::ENG_RX: begin
            if (scl_rise) begin
              shreg <= next_shreg;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                got_byte <= 1'b1;
                if (first) begin
                  reading <= bus.sda;
                  addr_valid <= addr_hit;
                  if (!addr_hit) state <= eeprom_cmd_pkg::ENG_IDLE;
                end else begin
                  rx_valid <= 1'b1;
                  rx_data <= next_shreg;
                end
              end
            end else if (scl_fall && got_byte) begin
              got_byte <= 1'b0;
              first <= 1'b0;
              state <= eeprom_cmd_pkg::ENG_ACK;
              o_sda_oe <= 1'b1; // ack every byte we accept
            end
          end
          eeprom_cmd_pkg::ENG_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (reading) begin
                state <= eeprom_cmd_pkg::ENG_TX;
                shreg <= bus.tx_data;
                tx_take <= 1'b1;
                o_sda_oe <= ~bus.tx_data[7];
              end else begin
                state <= eeprom_cmd_pkg::ENG_RX;
                o_sda_oe <= 1'b0;
              end
            end
          end
          eeprom_cmd_pkg::ENG_TX: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              shreg <= {shreg[6:0], 1'b0};
              o_sda_oe <= (bit_cnt == 3'h7) ? 1'b0 : ~shreg[6];
              if (bit_cnt == 3'h7) state <= eeprom_cmd_pkg::ENG_TXACK;
            end
          end
          eeprom_cmd_pkg::ENG_TXACK: begin
            // host nack ends the read; the engine then waits for stop
            if (scl_rise) begin
              state <= bus.sda ? eeprom_cmd_pkg::ENG_IDLE : eeprom_cmd_pkg::ENG_ACK;
            end
          end
        endcase
      end
    end
  end
endmodule

// ### verification/eeprom_access_cmd_asserts.sv
/*
  Concurrent checks on the ports of the EEPROM access command block.
  Assumes one core clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module eeprom_access_cmd_asserts #(
  parameter int ARB_LOSS_LIMIT = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // slave pins
  input wire logic i_scl,
  input wire logic o_sda_oe,
  // master request and events
  input wire logic o_ee_req,
  input wire logic [6:0] o_ee_dev_addr,
  input wire logic [15:0] o_ee_byte_addr,
  input wire logic i_ee_done,
  input wire logic i_ee_nack,
  input wire logic i_ee_arb_lost,
  input wire logic i_ee_arb_won,
  input wire logic i_ee_bus_cond_err,
  // status
  input wire logic o_busy,
  input wire logic o_nack_error_flag,
  input wire logic o_arbitration_lost_flag,
  input wire logic o_bus_condition_error_flag
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // ==========================================================================
  // run of consecutive lost arbitrations, cleared by a win or a new launch
  logic [5:0] run;
  logic [5:0] next_run;
  assign next_run = (i_ee_arb_won || o_ee_req) ? 6'h0 :
                    (i_ee_arb_lost && run != 6'h3f) ? run + 6'h1 : run;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) run <= 6'h0;
    else run <= next_run;
  end

  // ==========================================================================
  // launch and busy
  property p_req; o_ee_req |=> !o_ee_req; endproperty
  a_req: assert property (p_req) else $error("launch pulse longer than one cycle");
  property p_busy; o_ee_req |-> o_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy low at launch");
  property p_done; i_ee_done && o_busy |=> !o_busy; endproperty
  a_done: assert property (p_done) else $error("busy held after done");
  property p_hold; o_busy && !o_ee_req |-> $stable(o_ee_dev_addr) && $stable(o_ee_byte_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved while busy");

  // ==========================================================================
  // error flags; a set always wins over a clear
  property p_nack; i_ee_nack |=> o_nack_error_flag; endproperty
  a_nack: assert property (p_nack) else $error("nack flag not set");
  property p_cond; i_ee_bus_cond_err |=> o_bus_condition_error_flag; endproperty
  a_cond: assert property (p_cond) else $error("bus condition flag not set");
  property p_arb_set;
    i_ee_arb_lost && !i_ee_arb_won && !o_ee_req && run == ARB_LOSS_LIMIT - 1
      |=> o_arbitration_lost_flag;
  endproperty
  a_arb_set: assert property (p_arb_set) else $error("loss flag late");
  property p_arb_early; $rose(o_arbitration_lost_flag) |-> run >= ARB_LOSS_LIMIT; endproperty
  a_arb_early: assert property (p_arb_early) else $error("loss flag early");
  // flags only clear while the reply is clocked out, never on their own
  property p_clear;
    $fell(o_nack_error_flag) || $fell(o_arbitration_lost_flag) ||
      $fell(o_bus_condition_error_flag) |-> !i_scl;
  endproperty
  a_clear: assert property (p_clear) else $error("flag cleared outside a read");
  property p_oe; $rose(o_sda_oe) |-> !i_scl; endproperty
  a_oe: assert property (p_oe) else $error("data driven while scl high");
endmodule

bind eeprom_access_cmd eeprom_access_cmd_asserts #(.ARB_LOSS_LIMIT(ARB_LOSS_LIMIT)) u_chk (
  .i_clk, .i_rst_n, .i_scl, .o_sda_oe, .o_ee_req, .o_ee_dev_addr, .o_ee_byte_addr,
  .i_ee_done, .i_ee_nack, .i_ee_arb_lost, .i_ee_arb_won, .i_ee_bus_cond_err, .o_busy,
  .o_nack_error_flag, .o_arbitration_lost_flag, .o_bus_condition_error_flag);

// ### verification/smbus_host_model.sv
/*
  Behavioural slave-bus host: start, stop and byte transfers on scl and sda.
  Assumes i_sda is the resolved open-drain wire and that changes are made
  at the falling edge of the core clock, 16 clocks to an scl period.
*/
`timescale 1ns/1ps
module smbus_host_model (
  // core clock
  input wire logic i_clk,
  // resolved data wire
  input wire logic i_sda,
  // host drive, 1 releases the line to its pull-up
  output logic o_scl,
  output logic o_sda
);
  // ==========================================================================
  // bus idles high, scl stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // ==========================================================================
  // one bit: sda moves mid-low, sampled mid-high so the device never races it
  task automatic put_bit(input logic b, output logic r);
    o_sda = b;
    repeat (4) @(negedge i_clk);
    o_scl = 1'b1;
    repeat (4) @(negedge i_clk);
    r = i_sda;
    repeat (4) @(negedge i_clk);
    o_scl = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask

  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                      output logic ak);
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], rx[i]);
    end
    put_bit(ab, ak);
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic host_start;
    o_sda = 1'b1;
    repeat (4) @(negedge i_clk);
    o_scl = 1'b1;
    repeat (8) @(negedge i_clk);
    o_sda = 1'b0;
    repeat (8) @(negedge i_clk);
    o_scl = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask

  // stop: sda rises while scl is high
  task automatic host_stop;
    o_sda = 1'b0;
    repeat (4) @(negedge i_clk);
    o_scl = 1'b1;
    repeat (8) @(negedge i_clk);
    o_sda = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask
endmodule

// ### verification/tb.sv
/*
  Self-checking bench for the EEPROM access command block: host frames on
  the slave pins, master-side events from the bench.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] SLV = 7'h5d;
  logic clk, rst_n, scl, host_sda, sda_out, sda_oe, ee_read, ee_req, busy, ack;
  logic f_nack, f_arb, f_cond;
  logic [6:0] dev;
  logic [15:0] badr;
  logic [7:0] wdata, rdata;
  logic [4:0] evt;
  logic [7:0] got [6];
  int num_errors = 0;
  int cmp_count = 0;
  int req_cnt = 0;
  // open drain: pull-up unless the device pulls low
  wire sda_w = host_sda & ~(sda_oe & ~sda_out);

  // ==========================================================================
  // clock, launch counter, instances
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (ee_req === 1'b1) req_cnt++;

  smbus_host_model u_host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(host_sda));
  eeprom_access_cmd u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_w),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_slave_addr(SLV),
    .i_configured_eeprom_address(7'h33), .o_ee_req(ee_req), .o_ee_read(ee_read),
    .o_ee_dev_addr(dev), .o_ee_byte_addr(badr), .o_ee_wdata(wdata), .i_ee_done(evt[4]),
    .i_ee_rdata(rdata), .i_ee_nack(evt[3]), .i_ee_arb_lost(evt[2]), .i_ee_arb_won(evt[1]),
    .i_ee_bus_cond_err(evt[0]), .o_busy(busy), .o_nack_error_flag(f_nack),
    .o_arbitration_lost_flag(f_arb), .o_bus_condition_error_flag(f_cond));

  // ==========================================================================
  // tasks
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task put(input logic [7:0] b);
    logic [7:0] r;
    u_host.xfer(b, 1'b1, r, ack);
    chk("ack", 16'h0, 16'(ack));
  endtask
  // one-cycle master events: {done, nack, lost, won, cond}
  task ev(input logic [4:0] m);
    @(negedge clk);
    evt = m;
    @(negedge clk);
    evt = 5'h0;
  endtask
  // command frame; the stop launches the access
  task launch(input logic blk, input logic [7:0] cmd, input logic [7:0] ea,
              input logic [15:0] a, input logic [7:0] d, input logic hd);
    u_host.host_start;
    put({SLV, 1'b0});
    put(blk ? 8'h81 : 8'h01);
    if (blk) put(hd ? 8'h05 : 8'h04);
    put(cmd);
    put(ea);
    put(a[7:0]);
    put(a[15:8]);
    if (hd) put(d);
    u_host.host_stop;
    repeat (4) @(negedge clk);
  endtask
  // read back: the host nacks the last reply byte
  task rd_back(input logic blk);
    int n;
    n = blk ? 6 : 5;
    u_host.host_start;
    put({SLV, 1'b0});
    put(blk ? 8'h81 : 8'h01);
    u_host.host_start;
    put({SLV, 1'b1});
    for (int i = 0; i < n; i++) u_host.xfer(8'hff, i == n - 1, got[i], ack);
    u_host.host_stop;
    repeat (4) @(negedge clk);
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // watchdog: the sequence needs about 7300 cycles
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    complete_run;
  end

  // ==========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    evt = 5'h0;
    rdata = 8'h00;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    // block write to a supplied address
    launch(1'b1, 8'h02, 8'ha4, 16'h1234, 8'h5a, 1'b1);
    chk("launch", 16'd1, 16'(req_cnt));
    chk("op", 16'h0, 16'(ee_read));
    chk("dev", 16'h52, 16'(dev));
    chk("badr", 16'h1234, badr);
    chk("wdata", 16'h5a, 16'(wdata));
    chk("busy", 16'h1, 16'(busy));
    ev(5'h10);
    @(negedge clk);
    chk("busy", 16'h0, 16'(busy));
    // short-form read setup, configured address, reserved bits set on purpose
    launch(1'b0, 8'hc5, 8'hfe, 16'hbeef, 8'h00, 1'b0);
    chk("launch", 16'd2, 16'(req_cnt));
    chk("op", 16'h1, 16'(ee_read));
    chk("dev", 16'h33, 16'(dev));
    chk("badr", 16'hbeef, badr);
    ev(5'h08);
    ev(5'h01);
    chk("flags", 16'h5, 16'({f_cond, f_arb, f_nack}));
    rdata = 8'hc3;
    ev(5'h10);
    rd_back(1'b1);
    chk("count", 16'h05, 16'(got[0]));
    chk("cmd", 16'h29, 16'(got[1]));
    chk("alow", 16'hef, 16'(got[3]));
    chk("addrh", 16'hbe, 16'(got[4]));
    chk("data", 16'hc3, 16'(got[5]));
    chk("flags", 16'h0, 16'({f_cond, f_arb, f_nack}));
    rd_back(1'b0);
    chk("cmd", 16'h01, 16'(got[0]));
    chk("data", 16'hc3, 16'(got[4]));
    // lost arbitration: a win restarts the run
    launch(1'b0, 8'h03, 8'ha4, 16'hffff, 8'h00, 1'b0);
    chk("dev", 16'h52, 16'(dev));
    repeat (15) ev(5'h04);
    ev(5'h02);
    repeat (15) ev(5'h04);
    chk("arb", 16'h0, 16'(f_arb));
    ev(5'h04);
    chk("arb", 16'h1, 16'(f_arb));
    ev(5'h10);
    rd_back(1'b1);
    chk("cmd", 16'h13, 16'(got[1]));
    // a foreign slave address is neither acked nor launched
    u_host.host_start;
    u_host.xfer({7'h5e, 1'b0}, 1'b1, got[0], ack);
    u_host.host_stop;
    repeat (8) @(negedge clk);
    chk("nack", 16'h1, 16'(ack));
    chk("launch", 16'd3, 16'(req_cnt));
    complete_run;
  end
endmodule
